// ===== fsps_sequencer.sv
`timescale 1ns/1ps
// Purpose: run-time self-programming sequencer for the program flash
// Assumes: processor write strobes are one-cycle pulses, synchronous to clk_sys
// Notes: control and key registers reached through plain strobe ports
module fsps_sequencer
  import fsps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic ctl_wr,
  input wire logic [15:0] ctl_wdata,
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  input wire logic other_wr,
  input wire logic [FSPS_ADDR_W-1:0] tgt_addr,
  input wire logic [FSPS_WORD_W-1:0] tgt_data,
  output logic [15:0] ctl_rdata,
  output logic [7:0] key_rdata,
  output logic cpu_stall,
  output logic flash_prog,
  output logic flash_erase,
  output logic [FSPS_ADDR_W-1:0] flash_addr,
  output logic [FSPS_WORD_W-1:0] flash_wdata,
  output logic cfg_clear,
  output logic op_refused
);
  typedef struct packed {
    fsps_state_t st;
    logic [15:0] ctl;
    logic key_half;
    logic armed;
    logic stall;
    logic prog;
    logic erase;
    logic [FSPS_ADDR_W-1:0] addr;
    logic [FSPS_WORD_W-1:0] wdata;
    logic cfg_clr;
    logic refused;
    logic tstart;
    logic [FSPS_CNT_W-1:0] tcycles;
  } fsps_seq_st_t;

  fsps_seq_st_t s_r;
  fsps_seq_st_t s_nxt;
  fsps_timer_if tif();

  fsps_timer u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .osc_tick(osc_tick),
    .tif(tif)
  );

  logic is_erase;
  logic is_prog;
  logic start_req;

  assign is_erase = ctl_wdata[FSPS_CTL_ERASE_BIT] &&
                    ctl_wdata[FSPS_CTL_SEL_LO+3:FSPS_CTL_SEL_LO] == FSPS_SEL_PAGE;
  assign is_prog = !ctl_wdata[FSPS_CTL_ERASE_BIT] &&
                   ctl_wdata[FSPS_CTL_SEL_LO+3:FSPS_CTL_SEL_LO] == FSPS_SEL_WORD;
  assign start_req = ctl_wr && ctl_wdata[FSPS_CTL_START_BIT];

  always_comb begin
    s_nxt = s_r;
    s_nxt.tstart = 1'b0;
    s_nxt.refused = 1'b0;
    s_nxt.cfg_clr = 1'b0;
    // unlock tracking: any write other than the key pair drops it, except a start write while not idle (run or done)
    if (key_wr) begin
      if (s_r.key_half && key_wdata == FSPS_KEY_SECOND) begin
        s_nxt.armed = 1'b1;
        s_nxt.key_half = 1'b0;
      end else begin
        s_nxt.armed = 1'b0;
        s_nxt.key_half = (key_wdata == FSPS_KEY_FIRST);
      end
    end else if (other_wr || (ctl_wr && !start_req)) begin
      s_nxt.armed = 1'b0;
      s_nxt.key_half = 1'b0;
    end
    case (s_r.st)
      FSPS_ST_IDLE: begin
        if (ctl_wr) begin
          s_nxt.ctl = ctl_wdata & ~(16'h0001 << FSPS_CTL_START_BIT);
          if (start_req) begin
            s_nxt.armed = 1'b0;
            s_nxt.key_half = 1'b0;
            if (s_r.armed && (is_erase || is_prog)) begin
              s_nxt.ctl = ctl_wdata;
              s_nxt.st = FSPS_ST_RUN;
              s_nxt.stall = 1'b1;
              s_nxt.tstart = 1'b1;
              s_nxt.erase = is_erase;
              s_nxt.prog = is_prog;
              // erase works on the page base, program on one word
              s_nxt.addr = is_erase ?
                {fsps_page_of(tgt_addr), {FSPS_PAGE_SHIFT{1'b0}}} : tgt_addr;
              s_nxt.wdata = tgt_data;
              s_nxt.tcycles = is_erase ? FSPS_PAGE_ERASE_CNT : FSPS_ROW_WRITE_CNT;
              s_nxt.cfg_clr = is_erase && fsps_page_of(tgt_addr) == FSPS_LAST_PAGE;
            end else begin
              s_nxt.refused = 1'b1;
            end
          end
        end
      end
      FSPS_ST_RUN: begin
        if (tif.done) begin
          s_nxt.st = FSPS_ST_DONE;
          s_nxt.ctl[FSPS_CTL_START_BIT] = 1'b0;
          s_nxt.prog = 1'b0;
          s_nxt.erase = 1'b0;
        end
      end
      FSPS_ST_DONE: begin
        s_nxt.stall = 1'b0;
        s_nxt.st = FSPS_ST_IDLE;
      end
      default: begin
        s_nxt.st = FSPS_ST_IDLE;
        s_nxt.stall = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= FSPS_ST_IDLE;
      s_r.ctl <= FSPS_CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tif.start = s_r.tstart;
  assign tif.cycles = s_r.tcycles;

  assign ctl_rdata = s_r.ctl;
  assign key_rdata = 8'h00;
  assign cpu_stall = s_r.stall;
  assign flash_prog = s_r.prog;
  assign flash_erase = s_r.erase;
  assign flash_addr = s_r.addr;
  assign flash_wdata = s_r.wdata;
  assign cfg_clear = s_r.cfg_clr;
  assign op_refused = s_r.refused;

  a_start_needs_key: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_r.st == FSPS_ST_IDLE && start_req && !s_r.armed) |=> op_refused && !cpu_stall)
    else $error("start accepted without unlock");
  a_stall_during_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_r.st == FSPS_ST_RUN) |-> cpu_stall && ctl_rdata[FSPS_CTL_START_BIT])
    else $error("processor not stalled during operation");
  a_start_self_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_r.st == FSPS_ST_RUN && tif.done) |=> !ctl_rdata[FSPS_CTL_START_BIT] ##1 !cpu_stall)
    else $error("start bit not cleared at completion");
  a_key_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    key_wr |=> key_rdata == 8'h00)
    else $error("key contents visible on read");
  a_unlock_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (key_wr && key_wdata == FSPS_KEY_FIRST && !s_r.key_half) ##1
    (key_wr && key_wdata == FSPS_KEY_SECOND) |=> s_r.armed)
    else $error("unlock pair did not arm");
  a_unlock_cancel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (other_wr && !key_wr && !ctl_wr) |=> !s_r.armed && !s_r.key_half)
    else $error("foreign write did not cancel unlock");
  a_erase_page_base: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(flash_erase) |-> flash_addr[FSPS_PAGE_SHIFT-1:0] == '0)
    else $error("erase address not page aligned");
  a_last_page_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_clear |-> flash_erase && fsps_page_of(flash_addr) == FSPS_LAST_PAGE)
    else $error("config clear outside last page erase");
endmodule : fsps_sequencer

// ===== fsps_pkg.sv
// Purpose: constants and types for the flash self-program sequencer
// Assumes: 40 MHz system clock, fast rc oscillator tick arrives as a sync pulse
// Notes: the block has no software bus; control arrives as write strobes
// Summary of operation
// - flash rows hold 64 instruction words, which is 192 bytes.
// - an erase page is eight rows, 512 instruction words cleared together.
// - erase pages are aligned on 1536-byte boundaries from the start of memory.
// - a program operation writes exactly one 24-bit instruction word.
// - the processor is stalled for the whole program or erase operation.
// - writing one to bit 15 of the control register starts; hardware clears it at the end.
// - no operation starts unless the unlock was done just before.
// - the key register is write only and reads as zero.
// - the control register selects erase or program and holds the start trigger.
// - a row write lasts 355 fast rc oscillator cycles.
// - erasing the last page also clears the configuration words, enabling protection.
package fsps_pkg;
  localparam int unsigned FSPS_ROW_WORDS = 64;
  localparam int unsigned FSPS_ROW_BYTES = 192;
  localparam int unsigned FSPS_PAGE_ROWS = 8;
  localparam int unsigned FSPS_PAGE_WORDS = FSPS_ROW_WORDS * FSPS_PAGE_ROWS;
  localparam int unsigned FSPS_PAGE_BYTES = 1536;
  localparam int unsigned FSPS_WORD_W = 24;
  localparam int unsigned FSPS_ADDR_W = 16;
  localparam int unsigned FSPS_PAGE_W = 6;
  localparam int unsigned FSPS_PAGE_SHIFT = 10;
  localparam logic [FSPS_PAGE_W-1:0] FSPS_LAST_PAGE = 6'h1f;
  localparam int unsigned FSPS_CTL_START_BIT = 15;
  localparam int unsigned FSPS_CTL_ERASE_BIT = 6;
  localparam int unsigned FSPS_CTL_SEL_LO = 0;
  localparam logic [3:0] FSPS_SEL_WORD = 4'h3;
  localparam logic [3:0] FSPS_SEL_PAGE = 4'h2;
  localparam logic [7:0] FSPS_KEY_FIRST = 8'h55;
  localparam logic [7:0] FSPS_KEY_SECOND = 8'haa;
  localparam logic [15:0] FSPS_CTL_RESET = 16'h0000;
  localparam int unsigned FSPS_ROW_WRITE_OSC = 355;
  localparam int unsigned FSPS_PAGE_ERASE_OSC = 355;
  localparam int unsigned FSPS_CNT_W = 10;
  localparam logic [FSPS_CNT_W-1:0] FSPS_ROW_WRITE_CNT = FSPS_CNT_W'(FSPS_ROW_WRITE_OSC);
  localparam logic [FSPS_CNT_W-1:0] FSPS_PAGE_ERASE_CNT = FSPS_CNT_W'(FSPS_PAGE_ERASE_OSC);

  typedef enum logic [1:0] {FSPS_ST_IDLE, FSPS_ST_RUN, FSPS_ST_DONE} fsps_state_t;

  function automatic logic [FSPS_PAGE_W-1:0] fsps_page_of(input logic [FSPS_ADDR_W-1:0] a);
    fsps_page_of = a[FSPS_ADDR_W-1:FSPS_PAGE_SHIFT];
  endfunction : fsps_page_of
endpackage : fsps_pkg

// ===== fsps_timer_if.sv
`timescale 1ns/1ps
// Purpose: link between sequencer and its oscillator cycle timer
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
interface fsps_timer_if;
  import fsps_pkg::*;
  logic start;
  logic [FSPS_CNT_W-1:0] cycles;
  logic done;
  modport seq (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface : fsps_timer_if

// ===== fsps_timer.sv
`timescale 1ns/1ps
// Purpose: counts fast rc oscillator ticks for one flash operation
// Assumes: osc_tick is a one-cycle pulse per oscillator cycle
// Notes: done pulses one clock after the tick that ends the count
module fsps_timer
  import fsps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic osc_tick,
  fsps_timer_if.tmr tif
);
  typedef struct packed {
    logic busy;
    logic [FSPS_CNT_W-1:0] cnt;
    logic done;
  } fsps_tmr_st_t;

  fsps_tmr_st_t s_r;
  fsps_tmr_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (tif.start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = tif.cycles;
    end else if (s_r.busy && osc_tick) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
      if (s_r.cnt == FSPS_CNT_W'(1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tif.done = s_r.done;

  a_tick_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_r.busy && osc_tick && s_r.cnt == FSPS_CNT_W'(1)) |=> s_r.done && !s_r.busy)
    else $error("timer did not finish on last tick");
  a_hold_no_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_r.busy && !osc_tick && !tif.start) |=> $stable(s_r.cnt))
    else $error("timer moved without a tick");
endmodule : fsps_timer

// ===== fsps_cpu_model.sv
`timescale 1ns/1ps
// Purpose: processor core model issuing key and control writes
// Assumes: strobes change at the falling edge, one cycle wide
// Notes: oscillator tick runs free, one pulse per five clocks
module fsps_cpu_model
  import fsps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic osc_tick,
  output logic key_wr,
  output logic [7:0] key_wdata,
  output logic ctl_wr,
  output logic [15:0] ctl_wdata,
  output logic other_wr
);
  logic [2:0] div_r;
  initial begin
    {key_wr, ctl_wr, other_wr} = 3'h0;
    key_wdata = 8'h00;
    ctl_wdata = 16'h0000;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) div_r <= 3'h0;
    else div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
  end
  assign osc_tick = (div_r == 3'h4);
  // 0 key, 1 control, 2 other write; released data shows inverted
  task automatic put(input int w, input logic [15:0] v);
    @(negedge clk_sys);
    key_wr = (w == 0);
    ctl_wr = (w == 1);
    other_wr = (w == 2);
    key_wdata = v[7:0];
    ctl_wdata = v;
    @(negedge clk_sys);
    {key_wr, ctl_wr, other_wr} = 3'h0;
    key_wdata = ~key_wdata;
    ctl_wdata = ~ctl_wdata;
  endtask : put
  // two idle slots after the start write
  task automatic start(input logic [15:0] v);
    put(1, v);
    repeat (2) @(negedge clk_sys);
  endtask : start
endmodule : fsps_cpu_model

// ===== fsps_sequencer_bench.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: cpu model drives strobes at the falling edge
// Notes: rows erase a page before programming a word in it
module fsps_sequencer_bench
  import fsps_pkg::*;
();
  logic clk_sys, rst_n, osc_tick, key_wr, ctl_wr, other_wr;
  logic [7:0] key_wdata, key_rdata;
  logic [15:0] ctl_wdata, ctl_rdata, tgt_addr, flash_addr, s_addr;
  logic [23:0] tgt_data, flash_wdata, s_data;
  logic cpu_stall, flash_prog, flash_erase, cfg_clear, op_refused;
  logic s_stall, s_ref, s_prog, s_ers, s_cfg;
  int ticks, miscompares, comparisons, cycles;
  typedef struct packed {
    logic [7:0] k1; logic [7:0] k2; logic [15:0] c; logic [15:0] a;
    logic [23:0] d; logic ok; logic ers; logic cfg;
  } fsps_row_t;
  fsps_row_t rows [7];
  fsps_cpu_model cpu_u (.clk_sys, .rst_n, .osc_tick, .key_wr, .key_wdata, .ctl_wr,
    .ctl_wdata, .other_wr);
  fsps_sequencer dut_u (.clk_sys, .rst_n, .osc_tick, .ctl_wr, .ctl_wdata, .key_wr,
    .key_wdata, .other_wr, .tgt_addr, .tgt_data, .ctl_rdata, .key_rdata, .cpu_stall,
    .flash_prog, .flash_erase, .flash_addr, .flash_wdata, .cfg_clear, .op_refused);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cpu_stall === 1'b1) s_stall <= 1'b1;
    if (op_refused === 1'b1) s_ref <= 1'b1;
    if (cfg_clear === 1'b1) s_cfg <= 1'b1;
    if (flash_prog === 1'b1) s_prog <= 1'b1;
    if (flash_erase === 1'b1) s_ers <= 1'b1;
    if (cpu_stall === 1'b1 && osc_tick === 1'b1) ticks <= ticks + 1;
    if (flash_prog === 1'b1 || flash_erase === 1'b1) begin
      s_addr <= flash_addr;
      s_data <= flash_wdata;
    end
    if (cycles == 40000) begin
      miscompares++;
      results();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : check
  task automatic results;
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // key pair, optional stray write between, start, wait for release
  task automatic do_op(input logic [7:0] k1, input logic [7:0] k2, input logic mid,
    input logic [15:0] c);
    @(negedge clk_sys);
    {s_stall, s_ref, s_prog, s_ers, s_cfg} = 5'h00;
    ticks = 0;
    cpu_u.put(0, {8'h00, k1});
    if (mid) cpu_u.put(2, 16'h0000);
    cpu_u.put(0, {8'h00, k2});
    cpu_u.start(c);
    for (int n = 0; n < 4000 && cpu_stall !== 1'b0; n++) @(negedge clk_sys);
  endtask : do_op
  initial begin
    {rst_n, miscompares, comparisons, cycles} = '0;
    tgt_addr = 16'h0000;
    tgt_data = 24'h000000;
    rows[0] = {8'h55, 8'haa, 16'h8042, 16'h0400, 24'h000000, 3'b110};
    rows[1] = {8'h55, 8'haa, 16'h8003, 16'h0410, 24'h123456, 3'b100};
    rows[2] = {8'h55, 8'haa, 16'h8042, 16'h7c20, 24'h000000, 3'b111};
    rows[3] = {8'h55, 8'hab, 16'h8003, 16'h0420, 24'h00000f, 3'b000};
    rows[4] = {8'haa, 8'h55, 16'h8003, 16'h0420, 24'h00000f, 3'b000};
    rows[5] = {8'h55, 8'haa, 16'h8045, 16'h0420, 24'h00000f, 3'b000};
    rows[6] = {8'h55, 8'haa, 16'h8002, 16'h0420, 24'h00000f, 3'b000};
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      tgt_addr = rows[i].a;
      tgt_data = rows[i].d;
      do_op(rows[i].k1, rows[i].k2, 1'b0, rows[i].c);
      check("stall", s_stall, rows[i].ok);
      check("refused", s_ref, !rows[i].ok);
      check("erase", s_ers, rows[i].ok & rows[i].ers);
      check("prog", s_prog, rows[i].ok & !rows[i].ers);
      check("cfg", s_cfg, rows[i].cfg);
      check("ctl", ctl_rdata, {1'b0, rows[i].c[14:0]});
      if (rows[i].ok) begin
        check("addr", s_addr, rows[i].ers ? rows[i].a & 16'hfc00 : rows[i].a);
        check("ticks", ticks >= 355 && ticks <= 356, 1'b1);
        if (!rows[i].ers) check("data", s_data, rows[i].d);
      end
    end
    cpu_u.put(0, 16'h0055);
    check("key read", key_rdata, 8'h00);
    do_op(8'h55, 8'haa, 1'b1, 16'h8003);
    check("split key", {s_stall, s_ref}, 2'b01);
    cpu_u.put(0, 16'h0055);
    cpu_u.put(0, 16'h00aa);
    cpu_u.start(16'h8003);
    check("run", cpu_stall, 1'b1);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check("reset", {cpu_stall, flash_prog, ctl_rdata}, 18'h00000);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("after reset", {cpu_stall, flash_prog, flash_erase, op_refused, ctl_rdata}, 20'h00000);
    do_op(8'h55, 8'haa, 1'b0, 16'h8003);
    check("reset op prog", {s_prog, s_ref}, 2'b10);
    check("reset op data", s_data, tgt_data);
    results();
  end
endmodule : fsps_sequencer_bench
